/* File: hw/rtc_i2c_slave_port.sv */
// Two-wire bus slave port: link engine on the bus clock, user side on the system clock.
`timescale 1ns/100ps
`include "rtc_i2c_defs.svh"

module rtc_i2c_slave_port
    import rtc_i2c_pkg::*;
#(
    parameter int WR_DEPTH = 2
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic scl_clk,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    output logic bus_busy,
    output logic wr_valid,
    output rtc_wr_word_type wr_word,
    input wire logic wr_ready,
    output logic rd_req,
    output logic [`RTC_REG_ADDR_BITS-1:0] rd_addr,
    input wire logic [`RTC_BYTE_BITS-1:0] rd_data
);

    // =====================================================
    // Parameter check
    // =====================================================
    if (WR_DEPTH < 2) begin : g_check
        $error("WR_DEPTH must be at least 2");
    end

    // =====================================================
    // Declarations
    // =====================================================
    // System clock domain.
    logic link_rst_n_q;
    logic sda_out_q;
    logic scl_s1_q;
    logic scl_s2_q;
    logic sda_s1_q;
    logic sda_s2_q;
    logic sda_p_q;
    logic busy_q;
    logic wt_s1_q;
    logic wt_s2_q;
    logic wt_p_q;
    logic fr_s1_q;
    logic fr_s2_q;
    logic fr_p_q;
    rtc_wr_word_type hold_q;
    logic hold_v_q;
    logic hold_v_d;
    logic wr_full_q;
    logic buf_in_ready;
    rtc_fetch_state_type fst_q;
    rtc_fetch_state_type fst_d;
    logic rd_req_q;
    logic [`RTC_REG_ADDR_BITS-1:0] rd_addr_q;
    logic [`RTC_BYTE_BITS-1:0] fdata_q;
    logic ftgl_q;

    // Link clock domain.
    logic stop_tgl_q;
    logic stop_seen_q;
    logic sda_hi_q;
    logic [`RTC_BYTE_BITS-1:0] shift_q;
    logic fa_s1_q;
    logic fa_s2_q;
    logic fa_p_q;
    logic [`RTC_BYTE_BITS-1:0] rbuf_q;
    logic wf_s1_q;
    logic wf_s2_q;
    rtc_link_state_type st_q;
    rtc_link_state_type st_d;
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic oe_n_q;
    logic oe_n_d;
    logic first_q;
    logic first_d;
    logic [`RTC_REG_ADDR_BITS-1:0] ptr_q;
    logic [`RTC_REG_ADDR_BITS-1:0] ptr_d;
    rtc_wr_word_type wword_q;
    rtc_wr_word_type wword_d;
    logic wtgl_q;
    logic wtgl_d;
    logic freq_q;
    logic freq_d;
    logic [`RTC_BYTE_BITS-1:0] txsh_q;
    logic [`RTC_BYTE_BITS-1:0] txsh_d;

    // =====================================================
    // System side: reset for the link domain and pin watch
    // =====================================================
    // The bus clock may stand still, so the link flops are cleared asynchronously from this register.
    always_ff @(posedge clock) begin
        link_rst_n_q <= rstn;
        sda_out_q <= 1'b0;
    end

    // RULE4 start on data fall
    wire bus_start = scl_s2_q & sda_p_q & ~sda_s2_q;
    // RULE5 stop on data rise
    wire bus_stop = scl_s2_q & ~sda_p_q & sda_s2_q;

    // Both pins pass two flops before the bus watcher looks at them.
    always_ff @(posedge clock) begin
        if (!rstn) begin
            scl_s1_q <= `RTC_LINE_IDLE;
            scl_s2_q <= `RTC_LINE_IDLE;
            sda_s1_q <= `RTC_LINE_IDLE;
            sda_s2_q <= `RTC_LINE_IDLE;
            sda_p_q <= `RTC_LINE_IDLE;
            busy_q <= 1'b0;
        end else begin
            scl_s1_q <= scl_clk;
            scl_s2_q <= scl_s1_q;
            sda_s1_q <= sda_in;
            sda_s2_q <= sda_s1_q;
            sda_p_q <= sda_s2_q;
            busy_q <= (bus_stop) ? 1'b0 : (bus_start | busy_q);
        end
    end

    // RULE3 idle means not busy
    assign bus_busy = busy_q;

    // =====================================================
    // System side: write words from the link
    // =====================================================
    // Toggle handshake: the link word stays put for a whole byte time after its toggle.
    always_ff @(posedge clock) begin
        if (!rstn) begin
            wt_s1_q <= 1'b0;
            wt_s2_q <= 1'b0;
            wt_p_q <= 1'b0;
            hold_v_q <= 1'b0;
            wr_full_q <= 1'b0;
        end else begin
            wt_s1_q <= wtgl_q;
            wt_s2_q <= wt_s1_q;
            wt_p_q <= wt_s2_q;
            hold_v_q <= hold_v_d;
            wr_full_q <= hold_v_q & ~buf_in_ready;
        end
    end

    wire wr_ev = rtc_toggled(wt_s2_q, wt_p_q);
    assign hold_v_d = wr_ev | (hold_v_q & ~buf_in_ready);

    // Holding register in front of the buffer; it waits while the buffer is full.
    always_ff @(posedge clock) begin
        if (wr_ev) begin
            hold_q <= wword_q;
        end
    end

    // A stalled receiver fills the buffer, then the hold register, then data bytes are refused.
    rtc_fifo #(
        .WIDTH($bits(rtc_wr_word_type)),
        .DEPTH(WR_DEPTH)
    ) u_wr_fifo (
        .clock(clock),
        .rstn(rstn),
        .in_valid(hold_v_q),
        .in_ready(buf_in_ready),
        .in_data(hold_q),
        .out_valid(wr_valid),
        .out_ready(wr_ready),
        .out_data(wr_word)
    );

    // =====================================================
    // System side: register fetch for reads
    // =====================================================
    wire fetch_ev = rtc_toggled(fr_s2_q, fr_p_q);

    // Address goes out, user answers two cycles later, byte returns by toggle.
    always_comb begin
        fst_d = fst_q;
        case (fst_q)
            FT_IDLE: begin
                fst_d = FT_IDLE;
            end
            FT_WAIT: begin
                fst_d = FT_TAKE;
            end
            default: begin
                fst_d = FT_IDLE;
            end
        endcase
        if (fetch_ev) begin
            fst_d = FT_WAIT;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            fr_s1_q <= 1'b0;
            fr_s2_q <= 1'b0;
            fr_p_q <= 1'b0;
            fst_q <= FT_IDLE;
            rd_req_q <= 1'b0;
            rd_addr_q <= `RTC_PTR_RST;
            fdata_q <= `RTC_DATA_RST;
            ftgl_q <= 1'b0;
        end else begin
            fr_s1_q <= freq_q;
            fr_s2_q <= fr_s1_q;
            fr_p_q <= fr_s2_q;
            fst_q <= fst_d;
            rd_req_q <= fetch_ev;
            rd_addr_q <= fetch_ev ? ptr_q : rd_addr_q;
            fdata_q <= (fst_q == FT_TAKE) ? rd_data : fdata_q;
            ftgl_q <= ftgl_q ^ (fst_q == FT_TAKE);
        end
    end

    assign rd_req = rd_req_q;
    assign rd_addr = rd_addr_q;
    assign sda_out = sda_out_q;
    assign sda_oe_n = oe_n_q;

    // =====================================================
    // Link side: stop marker and rising-edge sampling
    // =====================================================
    // RULE5 stop marker
    // Clocked by the data pin; it is read at the next falling clock edge, long after it settled.
    always_ff @(posedge sda_in or negedge link_rst_n_q) begin
        if (!link_rst_n_q) begin
            stop_tgl_q <= 1'b0;
        end else if (scl_clk) begin
            stop_tgl_q <= ~stop_tgl_q;
        end
    end

    // RULE2 sample on clock high
    always_ff @(posedge scl_clk or negedge link_rst_n_q) begin
        if (!link_rst_n_q) begin
            sda_hi_q <= `RTC_LINE_IDLE;
            shift_q <= `RTC_DATA_RST;
            fa_s1_q <= 1'b0;
            fa_s2_q <= 1'b0;
            fa_p_q <= 1'b0;
            rbuf_q <= `RTC_DATA_RST;
            wf_s1_q <= 1'b0;
            wf_s2_q <= 1'b0;
        end else begin
            sda_hi_q <= sda_in;
            shift_q <= {shift_q[`RTC_BYTE_BITS-2:0], sda_in};
            fa_s1_q <= ftgl_q;
            fa_s2_q <= fa_s1_q;
            fa_p_q <= fa_s2_q;
            rbuf_q <= rtc_toggled(fa_s2_q, fa_p_q) ? fdata_q : rbuf_q;
            wf_s1_q <= wr_full_q;
            wf_s2_q <= wf_s1_q;
        end
    end

    // =====================================================
    // Link side: protocol engine on the falling clock edge
    // =====================================================
    // RULE4 start seen at fall
    // Data stable while high means a mismatch here is a start; a pending stop also opens a frame.
    wire start_ev = (sda_hi_q & ~sda_in) | (stop_tgl_q ^ stop_seen_q);
    wire byte_end = (cnt_q == `RTC_LAST_CNT);
    wire ack_end = (cnt_q == `RTC_ACK_CNT);
    // RULE12 fixed address match
    wire addr_hit = (shift_q[`RTC_BYTE_BITS-1:1] == `RTC_SLAVE_ADDR);
    // RULE14 direction bit
    wire dir_read = (shift_q[0] == `RTC_DIR_READ);
    // RULE6 eight bits plus acknowledge
    assign cnt_d = start_ev ? `RTC_CNT_RST : (ack_end ? `RTC_CNT_RST : cnt_q + 4'h1);

    always_comb begin
        st_d = st_q;
        oe_n_d = oe_n_q;
        first_d = first_q;
        ptr_d = ptr_q;
        wword_d = wword_q;
        wtgl_d = wtgl_q;
        freq_d = freq_q;
        txsh_d = txsh_q;
        if (start_ev) begin
            // RULE15 start ends transfer
            // RULE13 address byte follows
            st_d = LS_ADDR;
            oe_n_d = 1'b1;
        end else begin
            case (st_q)
                LS_ADDR: begin
                    if (byte_end && addr_hit) begin
                        // RULE9 drive acknowledge low
                        oe_n_d = 1'b0;
                        first_d = 1'b1;
                        st_d = dir_read ? LS_READ : LS_WRITE;
                    end else if (byte_end) begin
                        // RULE18 ignore until start
                        st_d = LS_IGNORE;
                    end
                end
                LS_WRITE: begin
                    if (byte_end && first_q) begin
                        // RULE16 low five bits
                        ptr_d = shift_q[`RTC_REG_ADDR_BITS-1:0];
                        first_d = 1'b0;
                        freq_d = ~freq_q;
                        // RULE7 acknowledge received byte
                        oe_n_d = 1'b0;
                    end else if (byte_end && !wf_s2_q) begin
                        wword_d.addr = ptr_q;
                        wword_d.data = shift_q;
                        wtgl_d = ~wtgl_q;
                        // RULE17 advance after write
                        ptr_d = rtc_ptr_next(ptr_q);
                        freq_d = ~freq_q;
                        oe_n_d = 1'b0;
                    end else if (ack_end) begin
                        oe_n_d = 1'b1;
                    end
                end
                LS_READ: begin
                    // RULE8 master acknowledge sampled
                    if (ack_end && (first_q || !sda_hi_q)) begin
                        // RULE19 read from pointer
                        txsh_d = {rbuf_q[`RTC_BYTE_BITS-2:0], 1'b1};
                        oe_n_d = rbuf_q[`RTC_BYTE_BITS-1];
                        // RULE17 advance after read
                        ptr_d = rtc_ptr_next(ptr_q);
                        freq_d = ~freq_q;
                        first_d = 1'b0;
                    end else if (ack_end) begin
                        // RULE11 release on no-acknowledge
                        // RULE10 master stops next
                        st_d = LS_IDLE;
                        oe_n_d = 1'b1;
                    end else if (byte_end) begin
                        oe_n_d = 1'b1;
                    end else begin
                        // RULE2 change only while low
                        oe_n_d = txsh_q[`RTC_BYTE_BITS-1];
                        txsh_d = {txsh_q[`RTC_BYTE_BITS-2:0], 1'b1};
                    end
                end
                default: begin
                    oe_n_d = 1'b1;
                end
            endcase
        end
    end

    // RULE1 frames open on every start, also mid-transfer
    always_ff @(negedge scl_clk or negedge link_rst_n_q) begin
        if (!link_rst_n_q) begin
            stop_seen_q <= 1'b0;
            st_q <= LS_IDLE;
            cnt_q <= `RTC_CNT_RST;
            oe_n_q <= 1'b1;
            first_q <= 1'b0;
            ptr_q <= `RTC_PTR_RST;
            wword_q <= '0;
            wtgl_q <= 1'b0;
            freq_q <= 1'b0;
            txsh_q <= `RTC_DATA_RST;
        end else begin
            stop_seen_q <= stop_tgl_q;
            st_q <= st_d;
            cnt_q <= cnt_d;
            oe_n_q <= oe_n_d;
            first_q <= first_d;
            ptr_q <= ptr_d;
            wword_q <= wword_d;
            wtgl_q <= wtgl_d;
            freq_q <= freq_d;
            txsh_q <= txsh_d;
        end
    end

endmodule

/* File: hw/rtc_i2c_defs.svh */
// Constants and field positions of the real-time clock two-wire slave port.
// Operation
// RULE1 - Master starts transfers only on idle bus.
// RULE2 - One bit per clock, stable while high.
// RULE3 - Both lines high means bus not busy.
// RULE4 - Data falling while clock high is start.
// RULE5 - Data rising while clock high is stop.
// RULE6 - Bytes of eight bits, each then acknowledged.
// RULE7 - Addressed receiving device acknowledges every byte. The code leaves a data byte unacknowledged while the write path is full.
// RULE8 - Master acknowledges read bytes except the last.
// RULE9 - Acknowledger holds data low through clock high.
// RULE10 - Master ends read with no-acknowledge, then stop.
// RULE11 - On master no-acknowledge, device releases data.
// RULE12 - Answer only to seven-bit address 1010001.
// RULE13 - Address byte follows every start condition.
// RULE14 - Address bit zero selects write or read.
// RULE15 - Write ends on stop or repeated start.
// RULE16 - First written byte: low five bits select register.
// RULE17 - Pointer advances after every data byte. A data byte refused while the write path is full leaves the pointer unchanged.
// RULE18 - Address mismatch: no acknowledge, ignore until start.
// RULE19 - Read starts at the current register pointer.
`ifndef RTC_I2C_DEFS_SVH
`define RTC_I2C_DEFS_SVH

// Field widths.
`define RTC_BYTE_BITS 8
`define RTC_REG_ADDR_BITS 5

// Address byte layout: address in bits 7..1, direction in bit 0.
`define RTC_SLAVE_ADDR 7'h51
`define RTC_DIR_READ 1'h1

// Clock count within a byte: last data clock and acknowledge clock.
`define RTC_LAST_CNT 4'h7
`define RTC_ACK_CNT 4'h8

// Reset values.
`define RTC_LINE_IDLE 1'h1
`define RTC_PTR_RST 5'h00
`define RTC_DATA_RST 8'h00
`define RTC_CNT_RST 4'h0

`endif

/* File: hw/rtc_i2c_pkg.sv */
// Types and helper functions shared by the two-wire slave port files.
`include "rtc_i2c_defs.svh"

package rtc_i2c_pkg;

    // Protocol state of the link-side engine.
    typedef enum logic [2:0] {
        LS_IDLE,
        LS_ADDR,
        LS_WRITE,
        LS_READ,
        LS_IGNORE
    } rtc_link_state_type;

    // State of the system-side register fetch.
    typedef enum logic [1:0] {
        FT_IDLE,
        FT_WAIT,
        FT_TAKE
    } rtc_fetch_state_type;

    // One register write handed to the user side.
    typedef struct packed {
        logic [`RTC_REG_ADDR_BITS-1:0] addr;
        logic [`RTC_BYTE_BITS-1:0] data;
    } rtc_wr_word_type;

    // A toggle event has arrived when the synchronised copy differs from the last seen one.
    function automatic logic rtc_toggled(input logic now_v, input logic seen_v);
        return now_v ^ seen_v;
    endfunction

    // Register pointer advance, wrapping inside the register space.
    function automatic logic [`RTC_REG_ADDR_BITS-1:0] rtc_ptr_next(input logic [`RTC_REG_ADDR_BITS-1:0] p);
        return p + `RTC_REG_ADDR_BITS'(1);
    endfunction

endpackage

/* File: hw/rtc_fifo.sv */
// Small shifting FIFO whose head entry is a register.
`timescale 1ns/100ps

module rtc_fifo #(
    parameter int WIDTH = 13,
    parameter int DEPTH = 2
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);

    localparam int CW = $clog2(DEPTH + 1);

    // =====================================================
    // Parameter check
    // =====================================================
    if (DEPTH < 2 || WIDTH < 1) begin : g_check
        $error("rtc_fifo needs DEPTH of at least 2 and WIDTH of at least 1");
    end

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [CW-1:0] count_q;
    logic [CW-1:0] count_d;
    logic [CW-1:0] slot;
    wire push = in_valid & in_ready;
    wire pop = out_valid & out_ready;

    // =====================================================
    // Occupancy
    // =====================================================
    // The new word lands behind the survivors of this cycle's pop.
    assign count_d = count_q + CW'(push) - CW'(pop);
    assign slot = count_q - CW'(pop);
    assign out_data = mem_q[0];

    // Flags are registered so that both handshake outputs come from flops.
    always_ff @(posedge clock) begin
        if (!rstn) begin
            count_q <= '0;
            in_ready <= 1'b1;
            out_valid <= 1'b0;
        end else begin
            count_q <= count_d;
            in_ready <= (count_d < CW'(DEPTH));
            out_valid <= (count_d != '0);
        end
    end

    // Storage shifts toward the head on a pop; data needs no reset.
    always_ff @(posedge clock) begin
        for (int i = 0; i < DEPTH; i++) begin
            if (push && slot == CW'(i)) begin
                mem_q[i] <= in_data;
            end else if (pop && i < DEPTH - 1) begin
                mem_q[i] <= mem_q[(i + 1) % DEPTH];
            end
        end
    end

endmodule

/* File: testbench/rtc_i2c_slave_port_sva.sv */
// Concurrent checks on the ports of the two-wire slave port, bound to its top module.
`timescale 1ns/100ps
`include "rtc_i2c_defs.svh"

// ==========================================
// Checker
module rtc_i2c_slave_port_sva
    import rtc_i2c_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic scl_clk,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe_n,
    input wire logic bus_busy,
    input wire logic wr_valid,
    input wire rtc_wr_word_type wr_word,
    input wire logic wr_ready,
    input wire logic rd_req,
    input wire logic [`RTC_REG_ADDR_BITS-1:0] rd_addr
);
    // All checks sample on the system clock, so link events are seen through it.
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    // Open drain: the pin can only ever be pulled low.
    property p_open_drain; sda_out == 1'h0; endproperty
    a_open_drain: assert property (p_open_drain) else $error("sda_out driven high");
    // The data drive may only move just after the bus clock falls.
    property p_oe_at_fall; $changed(sda_oe_n) |-> !scl_clk && $past(scl_clk); endproperty
    a_oe_at_fall: assert property (p_oe_at_fall) else $error("sda_oe_n moved outside clock low");
    property p_start_busy; $fell(sda_in) && scl_clk && $past(scl_clk) |-> ##[1:6] bus_busy; endproperty
    a_start_busy: assert property (p_start_busy) else $error("start not flagged busy");
    property p_stop_free; $rose(sda_in) && scl_clk && $past(scl_clk) |-> ##[1:6] !bus_busy; endproperty
    a_stop_free: assert property (p_stop_free) else $error("stop did not free bus");
    property p_idle_free; (scl_clk && sda_in) [*8] |-> !bus_busy; endproperty
    a_idle_free: assert property (p_idle_free) else $error("idle bus flagged busy");
    // A fetch request is a single-cycle pulse and its address holds between requests.
    property p_fetch_pulse; rd_req |=> !rd_req; endproperty
    a_fetch_pulse: assert property (p_fetch_pulse) else $error("rd_req longer than one cycle");
    property p_addr_hold; !rd_req |-> $stable(rd_addr); endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("rd_addr moved without rd_req");
    property p_word_hold; wr_valid && !wr_ready |=> wr_valid && $stable(wr_word); endproperty
    a_word_hold: assert property (p_word_hold) else $error("stalled write word lost");
endmodule

bind rtc_i2c_slave_port rtc_i2c_slave_port_sva u_sva (.clock(clock), .rstn(rstn), .scl_clk(scl_clk),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .bus_busy(bus_busy), .wr_valid(wr_valid),
    .wr_word(wr_word), .wr_ready(wr_ready), .rd_req(rd_req), .rd_addr(rd_addr));

/* File: testbench/rtc_i2c_master_model.sv */
// Behavioural bus master that drives the serial clock and its share of the data wire.
`timescale 1ns/100ps

// ==========================================
// Master model
module rtc_i2c_master_model (
    output logic scl_clk,
    output logic sda_m,
    input wire logic sda_in
);
    initial begin
        scl_clk = 1'h1;
        sda_m = 1'h1;
    end

    task automatic start();
        sda_m = 1'h1;
        #40 scl_clk = 1'h1;
        #40 sda_m = 1'h0;
        #40 scl_clk = 1'h0;
        #40;
    endtask

    task automatic stop();
        sda_m = 1'h0;
        #40 scl_clk = 1'h1;
        #40 sda_m = 1'h1;
        #80;
    endtask

    task automatic bit_cycle(input logic d, output logic q);
        sda_m = d;
        #40 scl_clk = 1'h1;
        #40 q = sda_in;
        #40 scl_clk = 1'h0;
        #40;
    endtask

    task automatic xfer_byte(input logic [7:0] d, input logic ack_in, output logic [7:0] q, output logic ack_out);
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(d[i], q[i]);
        end
        bit_cycle(ack_in, ack_out);
    endtask
endmodule

/* File: testbench/rtc_i2c_slave_port_bench.sv */
// Self-checking bench of the two-wire slave port driven by a behavioural master.
`timescale 1ns/100ps
`include "rtc_i2c_defs.svh"

`define CHK(name, exp, got) begin \
    total_checks++; \
    if ((got) !== (exp)) begin \
        n_mismatch++; \
        $display("ERROR %s expected %h seen %h", name, exp, got); \
    end \
end

// ==========================================
// Bench top
module rtc_i2c_slave_port_bench
    import rtc_i2c_pkg::*;
;
    logic clock = 1'h0;
    logic rstn = 1'h0;
    logic wr_ready = 1'h1;
    logic [7:0] rd_data = 8'h00;
    logic scl_clk, sda_m, sda_in, sda_out, sda_oe_n, bus_busy, wr_valid, rd_req, a;
    logic [4:0] rd_addr;
    logic [7:0] q;
    rtc_wr_word_type wr_word;
    rtc_wr_word_type got_q[$];
    int n_mismatch = 0;
    int total_checks = 0;
    int cycles = 0;

    // Register contents seen by the user side, a simple address-dependent pattern.
    function automatic logic [7:0] reg_val(input logic [4:0] ad);
        return {ad, 3'h5} ^ 8'h96;
    endfunction

    // Shared wire with pull-up: low whenever either party pulls it.
    assign sda_in = sda_m & (sda_oe_n ? 1'h1 : sda_out);

    initial begin
        forever #20 clock = ~clock;
    end

    rtc_i2c_slave_port #(.WR_DEPTH(2)) DUT (.clock(clock), .rstn(rstn), .scl_clk(scl_clk), .sda_in(sda_in),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .bus_busy(bus_busy), .wr_valid(wr_valid), .wr_word(wr_word),
        .wr_ready(wr_ready), .rd_req(rd_req), .rd_addr(rd_addr), .rd_data(rd_data));
    rtc_i2c_master_model u_master (.scl_clk(scl_clk), .sda_m(sda_m), .sda_in(sda_in));

    // User side: answer fetches one edge after the pulse and log accepted write words.
    always @(posedge clock) begin
        if (rd_req) begin
            rd_data <= #1 reg_val(rd_addr);
        end
        if (wr_valid && wr_ready) begin
            got_q.push_back(wr_word);
        end
    end

    // A hang counts as a mismatch; the tests need well under this many cycles.
    always @(posedge clock) begin
        cycles++;
        if (cycles == 6000) begin
            n_mismatch++;
            complete_run();
        end
    end

    task automatic complete_run();
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    // Sends one byte and checks the acknowledge level seen on the wire.
    task automatic put(input logic [7:0] d, input logic exp_ack);
        u_master.xfer_byte(d, 1'h1, q, a);
        `CHK("ack", exp_ack, a)
    endtask

    // Stalls lose no word, a full write path refuses a byte, upper pointer bits are ignored, the pointer wraps.
    task automatic t_write();
        logic [12:0] exp_w[4] = '{13'h1e3c, 13'h1f5a, 13'h0077, 13'h0111};
        wr_ready = 1'h0;
        u_master.start();
        put(8'ha2, 1'h0);
        `CHK("busy", 1'h1, bus_busy)
        put(8'hfe, 1'h0);
        put(8'h3c, 1'h0);
        put(8'h5a, 1'h0);
        put(8'h77, 1'h0);
        put(8'h99, 1'h1);
        `CHK("held", 1'h1, wr_valid)
        wr_ready = 1'h1;
        put(8'h11, 1'h0);
        u_master.stop();
        idle(12);
        `CHK("idle", 1'h0, bus_busy)
        `CHK("words", 4, got_q.size())
        for (int i = 0; i < 4 && i < got_q.size(); i++) begin
            `CHK("wr_word", exp_w[i], got_q[i])
        end
        got_q.delete();
    endtask

    // Pointer set, repeated start into a read, last byte refused, then a read that continues.
    task automatic t_read();
        u_master.start();
        put(8'ha2, 1'h0);
        put(8'h12, 1'h0);
        `CHK("rd_addr", 5'h12, rd_addr)
        u_master.start();
        put(8'ha3, 1'h0);
        for (int i = 0; i < 3; i++) begin
            u_master.xfer_byte(8'hff, 1'(i == 2), q, a);
            `CHK("rd_byte", reg_val(5'(18 + i)), q)
        end
        `CHK("released", 1'h1, sda_oe_n)
        u_master.stop();
        u_master.start();
        put(8'ha3, 1'h0);
        u_master.xfer_byte(8'hff, 1'h1, q, a);
        `CHK("rd_next", reg_val(5'h15), q)
        u_master.stop();
        idle(12);
    endtask

    // A foreign address is refused and the rest of the transfer ignored.
    task automatic t_foreign();
        u_master.start();
        put(8'ha0, 1'h1);
        put(8'h51, 1'h1);
        u_master.stop();
        idle(12);
        `CHK("no_word", 0, got_q.size())
    endtask

    // Main sequence: reset, then each scenario in turn.
    initial begin
        repeat (8) @(posedge clock);
        #1 rstn = 1'h1;
        idle(3);
        t_write();
        t_read();
        t_foreign();
        complete_run();
    end
endmodule
